// ### hw/sgc_pkg.sv
// shared constants and types of the slide gate input and setup control
package sgc_pkg;
   // ***************************************
   // clock and timing
   // ***************************************
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned HOLD_S = 1;
   localparam int unsigned SEC_CYC = CLK_HZ * HOLD_S;
   localparam int unsigned DEB_MS = 10;
   localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
   localparam int unsigned PAUSE_MS = 200;
   localparam int unsigned PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
   localparam int unsigned BACK_MS = 500;
   localparam int unsigned BACK_CYC = CLK_HZ / 1000 * BACK_MS;
   localparam logic [7:0] PROG_IDLE_S = 8'hB4;
   // ***************************************
   // auto close option coding
   // ***************************************
   localparam logic [6:0] AC_MAX_SEC = 7'h3B;
   localparam logic [6:0] AC_OPT_MAX = 7'h44;
   localparam logic [9:0] SEC_PER_MIN = 10'h03C;
   // ***************************************
   // register map and fields
   // ***************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] CMD_OFS = 4'h8;
   localparam int CTRL_LEFT_BIT = 0;
   localparam int CTRL_DUAL_BIT = 1;
   localparam int CTRL_AC_LSB = 2;
   localparam int CMD_OPEN_BIT = 0;
   localparam int CMD_CLOSE_BIT = 1;
   localparam int CMD_STOP_BIT = 2;
   localparam int CMD_CLEAR_BIT = 3;
   localparam logic CTRL_LEFT_RST = 1'b0;
   localparam logic CTRL_DUAL_RST = 1'b0;
   localparam logic [6:0] CTRL_AC_RST = 7'h00;
   // ***************************************
   // input bit positions
   // ***************************************
   localparam int NUM_IN = 13;
   localparam int IN_COBS = 0;
   localparam int IN_OOBS = 1;
   localparam int IN_ENTRAP = 2;
   localparam int IN_BACKOFF = 3;
   localparam int IN_OLOOP = 4;
   localparam int IN_RLOOP = 5;
   localparam int IN_SLOOP = 6;
   localparam int IN_OLIM = 7;
   localparam int IN_CLIM = 8;
   localparam int IN_UP = 9;
   localparam int IN_DOWN = 10;
   localparam int IN_ENTER = 11;
   localparam int IN_PEER = 12;
   typedef enum logic [2:0] {G_STOP, G_OPEN, G_OPENING, G_CLOSING, G_PAUSE, G_REV_OPEN, G_BACKOFF, G_LOCK} sgc_gate_t;
   typedef enum logic [2:0] {P_OFF, P_FUNC, P_SHOW, P_EDIT, P_STORED} sgc_prog_t;
endpackage : sgc_pkg

// ### hw/sgc_top.sv
// gate control, programming keys and ahb-lite settings registers
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sgc_top #(
   parameter int unsigned SEC_CYC = sgc_pkg::SEC_CYC,
   parameter int unsigned DEB_CYC = sgc_pkg::DEB_CYC,
   parameter int unsigned PAUSE_CYC = sgc_pkg::PAUSE_CYC,
   parameter int unsigned BACK_CYC = sgc_pkg::BACK_CYC
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [sgc_pkg::NUM_IN-1:0] pins_in,
   output logic motor_a_out,
   output logic motor_b_out,
   output logic alarm_out,
   output logic aux_relay_out,
   output logic link_dual_out,
   output logic prog_lamp_out,
   output logic dp_out,
   output logic flash_out,
   output logic [1:0] disp_func_out,
   output logic [6:0] disp_opt_out,
   output logic nv_store_out,
   output logic [8:0] nv_data_out
);
   import sgc_pkg::*;
   if (SEC_CYC < 4 || DEB_CYC < 1 || PAUSE_CYC < 1 || BACK_CYC < 1) begin : g_chk
      $error("sgc_top: timing parameters too small");
   end
   typedef struct packed {
      logic [NUM_IN-1:0] s1, s2, s3, db, dbq;
      logic [NUM_IN-1:0][31:0] dcnt;
      sgc_gate_t gst;
      logic [31:0] gcnt;
      logic strike, ac_dis;
      logic [9:0] ac_secs;
      logic [31:0] sec_cnt;
      logic tick;
      sgc_prog_t pst;
      logic [1:0] pfunc;
      logic [6:0] popt;
      logic [31:0] hold;
      logic [7:0] idle;
      logic left, dual;
      logic [6:0] ac_opt;
      logic nv_store, mot_a, mot_b, alarm, aux, plamp, dp, flash;
      logic ap_v, ap_w;
      logic [3:0] ap_a;
      logic [31:0] rdata;
      logic rdy, resp;
   } sgc_state_t;
   sgc_state_t q_reg, q_next;
   logic [NUM_IN-1:0] rise;
   logic cmd_open, cmd_close, cmd_stop, cmd_clear, both, ac_done, wr_ctrl;
   logic [9:0] ac_target;
   logic [6:0] omax;
   // ***************************************
   // combinational next state
   // ***************************************
   always_comb begin
      q_next = q_reg;
      // input synchroniser and debounce
      q_next.s1 = pins_in;
      q_next.s2 = q_reg.s1;
      q_next.s3 = q_reg.s2;
      q_next.dbq = q_reg.db;
      for (int i = 0; i < NUM_IN; i++) begin
         if (q_reg.s2[i] == q_reg.s3[i] && q_reg.s3[i] != q_reg.db[i]) begin
            if (q_reg.dcnt[i] >= DEB_CYC - 1) begin
               q_next.db[i] = q_reg.s3[i];
               q_next.dcnt[i] = 32'h0000_0000;
            end else begin
               q_next.dcnt[i] = q_reg.dcnt[i] + 32'h0000_0001;
            end
         end else begin
            q_next.dcnt[i] = 32'h0000_0000;
         end
      end
      rise = q_reg.db & ~q_reg.dbq;
      // one second tick
      q_next.tick = 1'b0;
      if (q_reg.sec_cnt >= SEC_CYC - 1) begin
         q_next.sec_cnt = 32'h0000_0000;
         q_next.tick = 1'b1;
      end else begin
         q_next.sec_cnt = q_reg.sec_cnt + 32'h0000_0001;
      end
      // bus address and data phase
      q_next.rdy = 1'b1;
      q_next.resp = 1'b0;
      q_next.ap_v = hsel_in && htrans_in[1] && hready_in;
      q_next.ap_w = hwrite_in;
      q_next.ap_a = haddr_in[3:0];
      q_next.rdata = 32'h0000_0000;
      if (hsel_in && htrans_in[1] && hready_in && !hwrite_in && haddr_in[31:4] == 28'h0000000) begin
         unique case (haddr_in[3:0])
            CTRL_OFS: q_next.rdata = {23'h000000, q_reg.ac_opt, q_reg.dual, q_reg.left};
            STAT_OFS: q_next.rdata = {21'h000000, q_reg.dual & q_reg.db[IN_PEER], q_reg.tick, 1'b0,
               q_reg.ac_dis, q_reg.pst, 1'b0, q_reg.gst};
            default: q_next.rdata = 32'h0000_0000;
         endcase
      end
      wr_ctrl = q_reg.ap_v && q_reg.ap_w && q_reg.ap_a == CTRL_OFS;
      cmd_open = q_reg.ap_v && q_reg.ap_w && q_reg.ap_a == CMD_OFS && hwdata_in[CMD_OPEN_BIT];
      cmd_close = q_reg.ap_v && q_reg.ap_w && q_reg.ap_a == CMD_OFS && hwdata_in[CMD_CLOSE_BIT];
      cmd_stop = q_reg.ap_v && q_reg.ap_w && q_reg.ap_a == CMD_OFS && hwdata_in[CMD_STOP_BIT];
      cmd_clear = q_reg.ap_v && q_reg.ap_w && q_reg.ap_a == CMD_OFS && hwdata_in[CMD_CLEAR_BIT];
      if (wr_ctrl && hwdata_in[CTRL_AC_LSB +: 7] <= AC_OPT_MAX) begin
         q_next.left = hwdata_in[CTRL_LEFT_BIT];
         q_next.dual = hwdata_in[CTRL_DUAL_BIT];
         q_next.ac_opt = hwdata_in[CTRL_AC_LSB +: 7];
      end
      // auto close delay in seconds
      if (q_reg.ac_opt <= AC_MAX_SEC) begin
         ac_target = {3'h0, q_reg.ac_opt};
      end else begin
         ac_target = 10'((q_reg.ac_opt - AC_MAX_SEC) * SEC_PER_MIN);
      end
      ac_done = q_reg.ac_opt != 7'h00 && !q_reg.ac_dis && q_reg.ac_secs >= ac_target;
      // gate sequencing
      q_next.gcnt = q_reg.gcnt + 32'h0000_0001;
      if (cmd_open || cmd_close || q_reg.db[IN_OLOOP]) begin
         q_next.ac_dis = 1'b0;
      end
      unique case (q_reg.gst)
         G_STOP: begin
            if (q_reg.db[IN_OLIM]) begin
               q_next.gst = G_OPEN;
            end else if (cmd_open || q_reg.db[IN_OLOOP]) begin
               q_next.gst = G_OPENING;
            end else if (cmd_close && !q_reg.db[IN_SLOOP] && !q_reg.db[IN_CLIM]) begin
               q_next.gst = G_CLOSING;
            end
         end
         G_OPEN: begin
            q_next.ac_secs = q_reg.ac_secs + {9'h000, q_reg.tick};
            if (q_reg.db[IN_SLOOP] || q_reg.db[IN_OLOOP] || q_reg.db[IN_COBS]) begin
               q_next.ac_secs = 10'h000;
            end else if (cmd_close || ac_done) begin
               q_next.gst = G_CLOSING;
               q_next.ac_secs = 10'h000;
            end
         end
         G_OPENING: begin
            if (q_reg.db[IN_OOBS] || q_reg.db[IN_ENTRAP]) begin
               q_next.gst = q_reg.strike ? G_LOCK : G_BACKOFF;
               q_next.strike = 1'b1;
               q_next.ac_dis = 1'b1;
               q_next.gcnt = 32'h0000_0000;
            end else if (q_reg.db[IN_COBS]) begin
               q_next.gst = G_PAUSE;
               q_next.gcnt = 32'h0000_0000;
            end else if (q_reg.db[IN_OLIM]) begin
               q_next.gst = G_OPEN;
               q_next.strike = 1'b0;
               q_next.ac_secs = 10'h000;
            end else if (cmd_stop && !q_reg.dual && !q_reg.db[IN_OLOOP]) begin
               q_next.gst = G_STOP;
            end
         end
         G_CLOSING: begin
            if (q_reg.db[IN_COBS] || q_reg.db[IN_BACKOFF] || q_reg.db[IN_RLOOP] || q_reg.db[IN_OLOOP] || cmd_open) begin
               q_next.gst = G_PAUSE;
               q_next.gcnt = 32'h0000_0000;
            end else if (q_reg.db[IN_CLIM]) begin
               q_next.gst = G_STOP;
               q_next.strike = 1'b0;
            end else if (cmd_stop && !q_reg.dual) begin
               q_next.gst = G_STOP;
            end
         end
         G_PAUSE: begin
            if (q_reg.gcnt >= PAUSE_CYC - 1) begin
               q_next.gst = G_REV_OPEN;
            end
         end
         G_REV_OPEN: begin
            if (q_reg.db[IN_OOBS] || q_reg.db[IN_ENTRAP]) begin
               q_next.gst = G_LOCK;
            end else if (q_reg.db[IN_OLIM]) begin
               q_next.gst = G_OPEN;
               q_next.ac_secs = 10'h000;
            end
         end
         G_BACKOFF: begin
            if (q_reg.gcnt >= BACK_CYC - 1 || q_reg.db[IN_CLIM]) begin
               q_next.gst = G_STOP;
            end
         end
         G_LOCK: begin
            if (cmd_clear) begin
               q_next.gst = G_STOP;
               q_next.strike = 1'b0;
            end
         end
      endcase
      // outputs from next gate state
      q_next.alarm = q_next.gst == G_LOCK;
      q_next.aux = q_next.gst inside {G_OPENING, G_CLOSING, G_PAUSE, G_REV_OPEN, G_BACKOFF};
      // programming keys
      both = q_reg.db[IN_UP] && q_reg.db[IN_DOWN] && (rise[IN_UP] || rise[IN_DOWN]);
      omax = q_reg.pfunc == 2'h2 ? AC_OPT_MAX : 7'h01;
      q_next.nv_store = 1'b0;
      if (|rise[IN_ENTER:IN_UP]) begin
         q_next.idle = 8'h00;
      end else if (q_reg.tick) begin
         q_next.idle = q_reg.idle + 8'h01;
      end
      if (q_reg.db[IN_ENTER] || (q_reg.db[IN_UP] && q_reg.db[IN_DOWN])) begin
         q_next.hold = q_reg.hold + 32'h0000_0001;
      end else begin
         q_next.hold = 32'h0000_0000;
      end
      if (q_reg.pst != P_OFF && (both || q_reg.idle >= PROG_IDLE_S)) begin
         q_next.pst = P_OFF;
      end else begin
         unique case (q_reg.pst)
            P_OFF: begin
               q_next.idle = 8'h00;
               if (!(q_reg.db[IN_UP] && q_reg.db[IN_DOWN])) begin
                  q_next.hold = 32'h0000_0000;
               end else if (q_reg.hold >= SEC_CYC - 1) begin
                  q_next.pst = P_FUNC;
                  q_next.pfunc = 2'h0;
               end
            end
            P_FUNC: begin
               if (rise[IN_UP]) begin
                  q_next.pfunc = q_reg.pfunc == 2'h2 ? 2'h0 : q_reg.pfunc + 2'h1;
               end else if (rise[IN_DOWN]) begin
                  q_next.pfunc = q_reg.pfunc == 2'h0 ? 2'h2 : q_reg.pfunc - 2'h1;
               end else if (rise[IN_ENTER]) begin
                  q_next.pst = P_SHOW;
                  q_next.hold = 32'h0000_0000;
               end
            end
            P_SHOW: begin
               if (q_reg.db[IN_ENTER] && q_reg.hold >= SEC_CYC - 1) begin
                  q_next.pst = P_EDIT;
               end else if (rise[IN_UP] || rise[IN_DOWN]) begin
                  q_next.pst = P_FUNC;
               end
               q_next.popt = q_reg.pfunc == 2'h0 ? {6'h00, q_reg.left}
                  : q_reg.pfunc == 2'h1 ? {6'h00, q_reg.dual} : q_reg.ac_opt;
            end
            P_EDIT: begin
               if (rise[IN_UP]) begin
                  q_next.popt = q_reg.popt >= omax ? 7'h00 : q_reg.popt + 7'h01;
               end else if (rise[IN_DOWN]) begin
                  q_next.popt = q_reg.popt == 7'h00 ? omax : q_reg.popt - 7'h01;
               end else if (rise[IN_ENTER]) begin
                  q_next.pst = P_STORED;
                  q_next.nv_store = 1'b1;
                  unique case (q_reg.pfunc)
                     2'h0: q_next.left = q_reg.popt[0];
                     2'h1: q_next.dual = q_reg.popt[0];
                     default: q_next.ac_opt = q_reg.popt;
                  endcase
               end
            end
            P_STORED: begin
               if (rise[IN_ENTER] || rise[IN_UP] || rise[IN_DOWN]) begin
                  q_next.pst = P_FUNC;
               end
            end
            default: q_next.pst = P_OFF;
         endcase
      end
      q_next.plamp = q_next.pst != P_OFF;
      q_next.dp = q_next.pst inside {P_SHOW, P_EDIT, P_STORED};
      q_next.flash = q_next.pst == P_EDIT && q_reg.sec_cnt < SEC_CYC / 2;
      // motor drive follows the handedness that will stand next cycle
      q_next.mot_a = q_next.left ? (q_next.gst == G_CLOSING || q_next.gst == G_BACKOFF)
         : (q_next.gst == G_OPENING || q_next.gst == G_REV_OPEN);
      q_next.mot_b = q_next.left ? (q_next.gst == G_OPENING || q_next.gst == G_REV_OPEN)
         : (q_next.gst == G_CLOSING || q_next.gst == G_BACKOFF);
   end
   // ***************************************
   // state register
   // ***************************************
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q_reg <= '0;
         q_reg.gst <= G_STOP;
         q_reg.pst <= P_OFF;
         q_reg.left <= CTRL_LEFT_RST;
         q_reg.dual <= CTRL_DUAL_RST;
         q_reg.ac_opt <= CTRL_AC_RST;
         q_reg.rdy <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end
   assign hrdata_out = q_reg.rdata;
   assign hreadyout_out = q_reg.rdy;
   assign hresp_out = q_reg.resp;
   assign motor_a_out = q_reg.mot_a;
   assign motor_b_out = q_reg.mot_b;
   assign alarm_out = q_reg.alarm;
   assign aux_relay_out = q_reg.aux;
   assign link_dual_out = q_reg.dual;
   assign prog_lamp_out = q_reg.plamp;
   assign dp_out = q_reg.dp;
   assign flash_out = q_reg.flash;
   assign disp_func_out = q_reg.pfunc;
   assign disp_opt_out = q_reg.popt;
   assign nv_store_out = q_reg.nv_store;
   assign nv_data_out = {q_reg.ac_opt, q_reg.dual, q_reg.left};
   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   AST_CLOSE_OBS_REV: assert property (q_reg.gst == G_CLOSING && q_reg.db[IN_COBS] |=> q_reg.gst == G_PAUSE)
      else $error("close obstruction did not stop gate");
   AST_PAUSE_TO_OPEN: assert property (q_reg.gst == G_PAUSE && q_reg.gcnt == PAUSE_CYC - 1
      |=> q_reg.gst == G_REV_OPEN && aux_relay_out)
      else $error("pause did not turn to reversal");
   AST_REV_LOCK: assert property (q_reg.gst == G_REV_OPEN && q_reg.db[IN_OOBS] |=> alarm_out ##1 alarm_out)
      else $error("reversal obstruction did not lock out");
   AST_BACKOFF_REQ: assert property (q_reg.gst == G_CLOSING && q_reg.db[IN_BACKOFF] |=> q_reg.gst == G_PAUSE)
      else $error("back-off request ignored");
   AST_REV_LOOP: assert property (q_reg.gst == G_CLOSING && q_reg.db[IN_RLOOP]
      |=> q_reg.gst == G_PAUSE && !motor_a_out && !motor_b_out)
      else $error("reverse loop ignored");
   AST_HOLD_OPEN: assert property (q_reg.gst == G_OPEN && (q_reg.db[IN_OLOOP] || q_reg.db[IN_SLOOP])
      |=> q_reg.gst == G_OPEN)
      else $error("gate left open position under loop");
   AST_AUX: assert property ((motor_a_out || motor_b_out) |-> aux_relay_out)
      else $error("relay idle while motor runs");
   AST_PROG_LAMP: assert property (prog_lamp_out == (q_reg.pst != P_OFF) && (!dp_out || prog_lamp_out))
      else $error("program lamp wrong");
   AST_PROG_EXIT: assert property (q_reg.pst == P_FUNC && rise[IN_DOWN] && q_reg.db[IN_UP] |=> !prog_lamp_out)
      else $error("programming not left");
   AST_STORE: assert property (q_reg.pst == P_EDIT && rise[IN_ENTER] && !rise[IN_UP] && !rise[IN_DOWN]
      && !(q_reg.db[IN_UP] && q_reg.db[IN_DOWN]) && q_reg.idle < PROG_IDLE_S |=> nv_store_out ##1 !nv_store_out)
      else $error("store pulse missing");
   AST_HAND: assert property (q_reg.gst == G_OPENING |-> motor_a_out != q_reg.left)
      else $error("direction does not follow handedness");
   AST_BACKOFF_END: assert property (q_reg.gst == G_BACKOFF && q_reg.gcnt == BACK_CYC - 1
      |=> q_reg.gst == G_STOP && q_reg.ac_dis)
      else $error("back-off did not end");
   COV_REV: cover property (q_reg.gst == G_PAUSE ##1 q_reg.gst == G_REV_OPEN);
   COV_LOCK: cover property (q_reg.gst == G_REV_OPEN ##1 q_reg.gst == G_LOCK);
   COV_STORE: cover property (q_reg.pst == P_EDIT ##1 q_reg.pst == P_STORED);
   COV_AC: cover property (q_reg.gst == G_OPEN && ac_done);
endmodule : sgc_top
`default_nettype wire

// ### tb/sgc_far_side.sv
// far side model: contacts, loops, keys, peer link and gate travel with limits
`timescale 1ns/1ps
`default_nettype none
module sgc_far_side #(
   parameter int TRAVEL = 30
) (
   input wire logic clk_in,
   input wire logic motor_a_in,
   input wire logic motor_b_in,
   input wire logic [sgc_pkg::NUM_IN-1:0] force_in,
   output logic [sgc_pkg::NUM_IN-1:0] pins_out
);
   import sgc_pkg::*;
   int pos = 0;
   // ***************************************
   // gate travel and limit switches
   // ***************************************
   always @(posedge clk_in) begin
      if (motor_a_in && pos < TRAVEL) pos <= pos + 1;
      if (motor_b_in && pos > 0) pos <= pos - 1;
   end
   always_comb begin
      pins_out = force_in;
      pins_out[IN_OLIM] = (pos == TRAVEL);
      pins_out[IN_CLIM] = (pos == 0);
   end
endmodule : sgc_far_side
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the slide gate control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sgc_pkg::*;
   localparam logic [31:0] AC = {28'h0, CTRL_OFS};
   localparam logic [31:0] AS = {28'h0, STAT_OFS};
   localparam logic [31:0] AM = {28'h0, CMD_OFS};
   localparam logic [12:0] KU = 13'h0200;
   localparam logic [12:0] KD = 13'h0400;
   localparam logic [12:0] KE = 13'h0800;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [12:0] frc = 13'h0;
   logic [12:0] pins;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hro, ok, ma, mb, alarm, aux, dual, lamp, dp, nvs, hresp, fl;
   logic hsel = 1'b0;
   int fh = 0;
   logic [1:0] func;
   logic [6:0] opt;
   logic [8:0] nvd;
   int fail_count = 0;
   int n_compared = 0;
   int stores = 0;
   sgc_top #(.SEC_CYC(20), .DEB_CYC(2), .PAUSE_CYC(3), .BACK_CYC(4)) uut (.sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hro), .hrdata_out(hrdata), .hreadyout_out(hro),
      .hresp_out(hresp), .pins_in(pins), .motor_a_out(ma), .motor_b_out(mb), .alarm_out(alarm),
      .aux_relay_out(aux), .link_dual_out(dual), .prog_lamp_out(lamp), .dp_out(dp), .flash_out(fl),
      .disp_func_out(func), .disp_opt_out(opt), .nv_store_out(nvs), .nv_data_out(nvd));
   sgc_far_side far (.clk_in(sys_clk_in), .motor_a_in(ma), .motor_b_in(mb), .force_in(frc), .pins_out(pins));
   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   always @(negedge sys_clk_in) if (nvs === 1'b1) stores++;
   // ***************************************
   // bus, wait and compare tasks
   // ***************************************
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask : idle
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hsel <= 1'b1;
      hwrite <= w;
      htrans <= 2'h2;
      do begin
         @(negedge sys_clk_in) ok = hro;
         @(posedge sys_clk_in);
      end while (ok !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(negedge sys_clk_in) ok = hro;
         rd = hrdata;
         @(posedge sys_clk_in);
      end while (ok !== 1'b1);
   endtask : bus
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_gate(input logic [2:0] g);
      int i;
      for (i = 0; i < 400; i++) begin
         bus(1'b0, AS, 32'h0);
         if (rd[2:0] === g) break;
      end
      check({29'h0, rd[2:0]}, {29'h0, g});
   endtask : wait_gate
   task automatic key(input logic [12:0] m, input int n);
      frc <= frc | m;
      idle(n);
      frc <= frc & ~m;
      idle(12);
   endtask : key
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #(25 * 40000);
      fail_count++;
      print_verdict();
   end
   // ***************************************
   // test sequence
   // ***************************************
   initial begin
      repeat (3) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      @(posedge sys_clk_in);
      bus(1'b0, AC, 32'h0);
      check(rd, 32'h0);
      check({27'h0, hresp, alarm, aux, dual, lamp}, 32'h0);
      bus(1'b1, AC, 32'h0000_00EE);
      frc[IN_PEER] <= 1'b1;
      idle(12);
      bus(1'b0, AS, 32'h0);
      check({31'h0, rd[10]}, 32'h1);
      check({31'h0, dual}, 32'h1);
      bus(1'b1, AC, 32'h0000_0114);
      bus(1'b0, AC, 32'h0);
      check(rd, 32'h0000_00EE);
      bus(1'b1, AC, 32'h0000_0110);
      bus(1'b0, AC, 32'h0);
      check(rd, 32'h0000_0110);
      bus(1'b1, AC, 32'h0000_0003);
      bus(1'b1, AM, 32'h1);
      wait_gate(G_OPENING);
      check({30'h0, ma, mb}, 32'h1);
      bus(1'b1, AM, 32'h4);
      idle(4);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h2);
      bus(1'b1, AC, 32'h0000_0001);
      bus(1'b1, AM, 32'h4);
      wait_gate(G_STOP);
      bus(1'b1, AC, 32'h0000_0004);
      frc[IN_SLOOP] <= 1'b1;
      bus(1'b1, AM, 32'h1);
      wait_gate(G_OPENING);
      check({29'h0, ma, mb, aux}, 32'h5);
      wait_gate(G_OPEN);
      idle(60);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h1);
      frc[IN_SLOOP] <= 1'b0;
      wait_gate(G_CLOSING);
      frc[IN_COBS] <= 1'b1;
      wait_gate(G_REV_OPEN);
      frc[IN_COBS] <= 1'b0;
      wait_gate(G_OPEN);
      wait_gate(G_CLOSING);
      foreach (frc[k]) begin
         if (k == IN_BACKOFF || k == IN_RLOOP) begin
            frc[k] <= 1'b1;
            wait_gate(G_REV_OPEN);
            frc[k] <= 1'b0;
            wait_gate(G_OPEN);
            wait_gate(G_CLOSING);
         end
      end
      frc[IN_BACKOFF] <= 1'b1;
      @(posedge sys_clk_in);
      frc[IN_BACKOFF] <= 1'b0;
      idle(12);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h3);
      check({31'h0, aux}, 32'h1);
      bus(1'b1, AC, 32'h0);
      wait_gate(G_STOP);
      frc[IN_OLOOP] <= 1'b1;
      wait_gate(G_OPEN);
      bus(1'b1, AM, 32'h2);
      idle(20);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h1);
      frc[IN_OLOOP] <= 1'b0;
      idle(12);
      bus(1'b1, AM, 32'h2);
      wait_gate(G_CLOSING);
      frc[IN_COBS] <= 1'b1;
      wait_gate(G_REV_OPEN);
      frc[IN_OOBS] <= 1'b1;
      wait_gate(G_LOCK);
      check({31'h0, alarm}, 32'h1);
      frc[IN_COBS] <= 1'b0;
      frc[IN_OOBS] <= 1'b0;
      bus(1'b1, AM, 32'h8);
      wait_gate(G_STOP);
      idle(12);
      bus(1'b1, AM, 32'h2);
      wait_gate(G_CLOSING);
      wait_gate(G_STOP);
      bus(1'b1, AM, 32'h1);
      wait_gate(G_OPENING);
      frc[IN_OOBS] <= 1'b1;
      wait_gate(G_BACKOFF);
      frc[IN_OOBS] <= 1'b0;
      wait_gate(G_STOP);
      check({31'h0, rd[7]}, 32'h1);
      key(KU | KD, 40);
      check({31'h0, lamp}, 32'h1);
      key(KU, 8);
      check({30'h0, func}, 32'h1);
      key(KE, 8);
      check({31'h0, dp}, 32'h1);
      key(KE, 40);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[6:4]}, 32'h3);
      repeat (20) begin
         @(negedge sys_clk_in) fh += fl;
      end
      @(posedge sys_clk_in);
      check(fh, 32'h0000_000A);
      key(KU, 8);
      check({25'h0, opt}, 32'h1);
      key(KE, 8);
      check({stores[22:0], nvd}, 32'h0000_0202);
      key(KU, 8);
      bus(1'b0, AS, 32'h0);
      check({29'h0, rd[6:4]}, 32'h1);
      frc[IN_UP] <= 1'b1;
      idle(10);
      key(KD, 10);
      frc[IN_UP] <= 1'b0;
      idle(12);
      check({31'h0, lamp}, 32'h0);
      key(KU | KD, 40);
      idle(3700);
      check({31'h0, lamp}, 32'h0);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
